// [hw/rsa_pkg.sv]
// Shared constants and types for the rectifier status and alarm readback.
// Assumes a single 50 MHz clock domain and an SMBus slave port on pins.
package rsa_pkg;

  // Command codes answered by the readback block.
  localparam logic [7:0] CMD_SUMMARY = 8'hD0;
  localparam logic [7:0] CMD_UNIT = 8'hD1;
  localparam logic [7:0] CMD_ALARM = 8'hD2;
  localparam logic [7:0] CMD_NONE = 8'h00;

  // Frame layout: leading byte count and index of the check byte.
  localparam logic [7:0] SUMMARY_COUNT = 8'h0B;
  localparam logic [7:0] ALARM_COUNT = 8'h03;
  localparam logic [3:0] SUMMARY_PEC_IDX = 4'hC;
  localparam logic [3:0] UNIT_PEC_IDX = 4'h2;
  localparam logic [3:0] ALARM_PEC_IDX = 4'h4;
  localparam logic [3:0] IDX_MAX = 4'hF;

  // Fill values for bytes past the check byte and for data not gathered in time.
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [15:0] FILL_WORD = 16'hFFFF;

  // Current-share limit for the power delivery alarm, 10000 mA.
  localparam logic [15:0] SHARE_LIMIT_MA = 16'h2710;

  // Slave address on the management bus.
  localparam logic [6:0] SLAVE_ADDR = 7'h58;

  // Packet error code polynomial x^8+x^2+x+1 and its start value.
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;

  // Values of the readback registers before the first snapshot.
  localparam logic [7:0] STATUS_HIGH_RESET = 8'h40;
  localparam logic [7:0] STATUS_LOW_RESET = 8'h80;
  localparam logic [7:0] ALARM_RESET = 8'h00;

  // Bit counter values.
  localparam logic [3:0] BITS_NONE = 4'h0;
  localparam logic [3:0] BITS_ONE = 4'h1;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_CMD = 3'b011,
    ST_CMD_ACK = 3'b100,
    ST_WBYTE = 3'b101,
    ST_TX = 3'b110,
    ST_TX_ACK = 3'b111
  } link_state_t;

  // Level flags from the rectifier's own control logic.
  typedef struct packed {
    logic oc_hiccup;
    logic oring_test_failed;
    logic value_range_flag;
    logic ot_hiccup;
    logic oring_test_ok;
    logic internal_fault;
    logic shutdown;
    logic service_led;
    logic external_fault;
    logic lamp_check_active;
    logic output_on;
    logic interlock_open;
    logic fuse_fail;
    logic pfc_link_fault;
    logic dc_link_fault;
    logic ac_link_fault;
    logic fan_fault;
    logic no_primary;
    logic primary_ot;
    logic dcdc_ot;
    logic below_bus;
    logic sensor_fail;
    logic aux_rail_bad;
    logic power_limit;
    logic primary_fault;
    logic thermal_trip;
    logic ot_warning;
    logic in_overcurrent;
    logic overvoltage_trip;
    logic output_voltage_bad;
    logic input_voltage_bad;
  } unit_flags_t;

  // One coherent copy of everything a read may return.
  typedef struct packed {
    logic [7:0] unit_status_high;
    logic [7:0] unit_status_low;
    logic [7:0] alarm_hardware;
    logic [7:0] alarm_thermal_fan;
    logic [7:0] alarm_limits;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] temp;
  } snap_t;

endpackage

// [hw/pec_crc8.sv]
// Running packet error code over the bytes of one bus transaction.
// Assumes clear and feed come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module pec_crc8 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Byte feed
  input wire logic clear,
  input wire logic feed,
  input wire logic [7:0] data,
  // Running check value
  output logic [7:0] crc
);

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ rsa_pkg::PEC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_b || clear) begin
      crc <= rsa_pkg::PEC_INIT;
    end else if (feed) begin
      crc <= crc_step(crc, data);
    end
  end

endmodule // pec_crc8
`default_nettype wire

// [hw/status_readback.sv]
// SMBus slave that returns the rectifier's status and alarm readback.
// Assumes open-drain SCL/SDA pins resolved outside; unit flags same clock.
// Function
// - Replies longer than two bytes use block read after command write.
// - First block byte counts the data bytes, check byte excluded.
// - Analog words go out low byte first, then high byte.
// - Summary: count 11, five flag bytes, voltage, current, temperature.
// - Summary temperature is the reading nearest its trip level.
// - Unit status command returns both status bytes as a word read.
// - Status high byte layout with overcurrent mode and remote level.
// - Status low byte layout with overtemperature mode and lamp check.
// - Alarm command returns hardware, thermal-fan, then limits bytes.
// - Hardware alarm byte layout; bits 2 and 1 read zero.
// - Thermal-fan alarm byte layout, all clear by default.
// - Limits alarm byte layout, all clear by default.
// - Power delivery alarm when share current exceeds 10 A.
// - Either test raises the or'ing fault; only destructive ones trip.
// - Data not gathered in time is returned as all ones.
`timescale 1ns/1ns
`default_nettype none
module status_readback (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Management bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Remote on/off pin
  input wire logic remote_pin,
  // Unit flags and measurements
  input wire rsa_pkg::unit_flags_t flags,
  input wire logic [15:0] volt,
  input wire logic [15:0] curr,
  input wire logic [15:0] temp_a,
  input wire logic [15:0] trip_a,
  input wire logic [15:0] temp_b,
  input wire logic [15:0] trip_b,
  input wire logic [15:0] share_ma,
  input wire logic data_valid,
  // Or'ing test events
  input wire logic host_oring_fail,
  input wire logic self_oring_fail,
  input wire logic oring_destructive,
  input wire logic restart,
  // Shutdown request to the power stage
  output logic shutdown_req
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  rsa_pkg::link_state_t state_q;
  rsa_pkg::snap_t snap_q;
  rsa_pkg::snap_t snap_d;
  logic scl_s1_q, scl_s2_q, scl_d3_q;
  logic sda_s1_q, sda_s2_q, sda_d3_q;
  logic rem_s1_q, rem_s2_q;
  logic [3:0] cnt_q;
  logic [3:0] idx_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] cmd_q;
  logic [7:0] byte_q;
  logic rw_q, cmd_seen_q, mack_q;
  logic pec_err_q, invalid_q, oring_fault_q, power_delivery_q;
  logic [7:0] pec_crc;
  logic [7:0] eff_cmd;
  logic [7:0] byte_d;
  logic [15:0] temp_pick;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic addr_hit, byte_done, load_now, snap_take, read_done;
  logic set_invalid, set_pec, clr_unit, clr_alarm;
  logic crc_clear, crc_feed;

  function automatic logic known_cmd(input logic [7:0] c);
    return (c == rsa_pkg::CMD_SUMMARY) || (c == rsa_pkg::CMD_UNIT) ||
           (c == rsa_pkg::CMD_ALARM);
  endfunction

  // Index of the check byte; zero for commands this block does not answer.
  function automatic logic [3:0] pec_idx(input logic [7:0] c);
    case (c)
      rsa_pkg::CMD_SUMMARY: return rsa_pkg::SUMMARY_PEC_IDX;
      rsa_pkg::CMD_UNIT: return rsa_pkg::UNIT_PEC_IDX;
      rsa_pkg::CMD_ALARM: return rsa_pkg::ALARM_PEC_IDX;
      default: return rsa_pkg::BITS_NONE;
    endcase
  endfunction

  function automatic logic [15:0] trip_margin(input logic [15:0] t,
                                              input logic [15:0] trip);
    return (t >= trip) ? 16'h0000 : trip - t;
  endfunction

  // Byte number idx of the reply; past the check byte the line reads ones.
  function automatic logic [7:0] frame_byte(input logic [7:0] c,
                                            input logic [3:0] idx,
                                            input rsa_pkg::snap_t s,
                                            input logic [7:0] pec);
    logic [7:0] b;
    b = rsa_pkg::FILL_BYTE;
    case (c)
      rsa_pkg::CMD_SUMMARY: begin
        case (idx)
          4'h0: b = rsa_pkg::SUMMARY_COUNT;
          4'h1: b = s.unit_status_high;
          4'h2: b = s.unit_status_low;
          4'h3: b = s.alarm_hardware;
          4'h4: b = s.alarm_thermal_fan;
          4'h5: b = s.alarm_limits;
          4'h6: b = s.volt[7:0];
          4'h7: b = s.volt[15:8];
          4'h8: b = s.curr[7:0];
          4'h9: b = s.curr[15:8];
          4'hA: b = s.temp[7:0];
          4'hB: b = s.temp[15:8];
          4'hC: b = pec;
          default: b = rsa_pkg::FILL_BYTE;
        endcase
      end
      rsa_pkg::CMD_UNIT: begin
        case (idx)
          4'h0: b = s.unit_status_high;
          4'h1: b = s.unit_status_low;
          4'h2: b = pec;
          default: b = rsa_pkg::FILL_BYTE;
        endcase
      end
      rsa_pkg::CMD_ALARM: begin
        case (idx)
          4'h0: b = rsa_pkg::ALARM_COUNT;
          4'h1: b = s.alarm_hardware;
          4'h2: b = s.alarm_thermal_fan;
          4'h3: b = s.alarm_limits;
          4'h4: b = pec;
          default: b = rsa_pkg::FILL_BYTE;
        endcase
      end
      default: b = rsa_pkg::FILL_BYTE;
    endcase
    return b;
  endfunction

  // Pin synchronisers; edge detection looks only at the second stage on.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_d3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_d3_q <= 1'b1;
      rem_s1_q <= 1'b0;
      rem_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_d3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_d3_q <= sda_s2_q;
      rem_s1_q <= remote_pin;
      rem_s2_q <= rem_s1_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_d3_q;
  assign scl_fall = ~scl_s2_q & scl_d3_q;
  assign start_det = scl_s2_q & scl_d3_q & sda_d3_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_d3_q & ~sda_d3_q & sda_s2_q;
  assign addr_hit = (rx_q[7:1] == rsa_pkg::SLAVE_ADDR);
  assign eff_cmd = cmd_seen_q ? cmd_q : rsa_pkg::CMD_NONE;
  assign byte_d = frame_byte(eff_cmd, idx_q, snap_q, pec_crc);
  assign byte_done = scl_fall && (cnt_q == rsa_pkg::BITS_BYTE) &&
                     ((state_q == rsa_pkg::ST_ADDR) ||
                      (state_q == rsa_pkg::ST_CMD) ||
                      (state_q == rsa_pkg::ST_WBYTE));
  assign snap_take = byte_done && (state_q == rsa_pkg::ST_ADDR) &&
                     addr_hit && rx_q[0];
  // A reply starts after the read address and goes on while the host acks.
  assign load_now = scl_fall &&
                    (((state_q == rsa_pkg::ST_ADDR_ACK) && rw_q) ||
                     ((state_q == rsa_pkg::ST_TX_ACK) && mack_q));
  // The host ends a reply by leaving the check byte unacknowledged.
  assign read_done = scl_fall && (state_q == rsa_pkg::ST_TX_ACK) &&
                     !mack_q;

  // Bus state machine; open-drain SDA is only ever pulled low.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= rsa_pkg::ST_IDLE;
      cnt_q <= rsa_pkg::BITS_NONE;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      cmd_q <= rsa_pkg::CMD_NONE;
      cmd_seen_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (stop_det) begin
      state_q <= rsa_pkg::ST_IDLE;
      cmd_seen_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state_q <= rsa_pkg::ST_ADDR;
      cnt_q <= rsa_pkg::BITS_NONE;
      sda_oe <= 1'b0;
    end else if (load_now) begin
      sda_oe <= ~byte_d[7];
      tx_q <= {byte_d[6:0], 1'b0};
      cnt_q <= rsa_pkg::BITS_ONE;
      state_q <= rsa_pkg::ST_TX;
    end else begin
      case (state_q)
        rsa_pkg::ST_ADDR, rsa_pkg::ST_CMD, rsa_pkg::ST_WBYTE: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + rsa_pkg::BITS_ONE;
          end else if (byte_done) begin
            cnt_q <= rsa_pkg::BITS_NONE;
            if (state_q == rsa_pkg::ST_ADDR && !addr_hit) begin
              state_q <= rsa_pkg::ST_IDLE;
            end else if (state_q == rsa_pkg::ST_ADDR) begin
              sda_oe <= 1'b1;
              rw_q <= rx_q[0];
              state_q <= rsa_pkg::ST_ADDR_ACK;
            end else begin
              sda_oe <= 1'b1;
              state_q <= rsa_pkg::ST_CMD_ACK;
            end
            if (state_q == rsa_pkg::ST_CMD) begin
              cmd_q <= rx_q;
              cmd_seen_q <= 1'b1;
            end
          end
        end
        rsa_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state_q <= rsa_pkg::ST_CMD;
          end
        end
        rsa_pkg::ST_CMD_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state_q <= rsa_pkg::ST_WBYTE;
          end
        end
        rsa_pkg::ST_TX: begin
          if (scl_fall && cnt_q == rsa_pkg::BITS_BYTE) begin
            sda_oe <= 1'b0;
            state_q <= rsa_pkg::ST_TX_ACK;
          end else if (scl_fall) begin
            sda_oe <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + rsa_pkg::BITS_ONE;
          end
        end
        rsa_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s2_q;
          end else if (scl_fall) begin
            state_q <= rsa_pkg::ST_IDLE;
          end
        end
        default: state_q <= rsa_pkg::ST_IDLE;
      endcase
    end
  end

  // Reply byte pointer and the byte last put on the line.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      idx_q <= rsa_pkg::BITS_NONE;
      byte_q <= 8'h00;
    end else if (snap_take) begin
      idx_q <= rsa_pkg::BITS_NONE;
    end else if (load_now) begin
      byte_q <= byte_d;
      if (idx_q != rsa_pkg::IDX_MAX) begin
        idx_q <= idx_q + rsa_pkg::BITS_ONE;
      end
    end
  end

  // Check code covers address, command, read address and data bytes.
  assign crc_clear = stop_det || (start_det && state_q == rsa_pkg::ST_IDLE);
  assign crc_feed = (byte_done && state_q != rsa_pkg::ST_WBYTE &&
                     (state_q != rsa_pkg::ST_ADDR || addr_hit)) ||
                    (load_now && idx_q < pec_idx(eff_cmd));

  pec_crc8 u_pec (
    .mclk(mclk),
    .rst_b(rst_b),
    .clear(crc_clear),
    .feed(crc_feed),
    .data(load_now ? byte_d : rx_q),
    .crc(pec_crc)
  );

  // Sticky flags; a set in the cycle of a clear wins.
  assign set_invalid = (byte_done && state_q == rsa_pkg::ST_CMD &&
                        !known_cmd(rx_q)) || (snap_take && !cmd_seen_q);
  assign set_pec = byte_done && state_q == rsa_pkg::ST_WBYTE &&
                   rx_q != pec_crc;
  assign clr_unit = read_done && (eff_cmd == rsa_pkg::CMD_SUMMARY ||
                                  eff_cmd == rsa_pkg::CMD_UNIT);
  assign clr_alarm = read_done && (eff_cmd == rsa_pkg::CMD_SUMMARY ||
                                   eff_cmd == rsa_pkg::CMD_ALARM);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pec_err_q <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      pec_err_q <= set_pec | (pec_err_q & ~clr_unit);
      invalid_q <= set_invalid | (invalid_q & ~clr_unit);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      oring_fault_q <= 1'b0;
      shutdown_req <= 1'b0;
    end else begin
      oring_fault_q <= host_oring_fail | self_oring_fail |
                       (oring_fault_q & ~clr_alarm);
      shutdown_req <= oring_destructive | (shutdown_req & ~restart);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_delivery_q <= 1'b0;
    end else begin
      power_delivery_q <= share_ma > rsa_pkg::SHARE_LIMIT_MA;
    end
  end

  assign temp_pick = (trip_margin(temp_a, trip_a) <=
                      trip_margin(temp_b, trip_b)) ? temp_a : temp_b;

  always_comb begin
    snap_d.unit_status_high = {pec_err_q, flags.oc_hiccup, invalid_q, 1'b0,
                               flags.oring_test_failed, 1'b0,
                               flags.value_range_flag, rem_s2_q};
    snap_d.unit_status_low = {flags.ot_hiccup, flags.oring_test_ok,
                              flags.internal_fault,
                              flags.shutdown | shutdown_req,
                              flags.service_led, flags.external_fault,
                              flags.lamp_check_active,
                              flags.output_on};
    snap_d.alarm_hardware = {flags.interlock_open, flags.fuse_fail,
                             flags.pfc_link_fault, flags.dc_link_fault,
                             flags.ac_link_fault, 2'b00,
                             oring_fault_q};
    snap_d.alarm_thermal_fan = {flags.fan_fault, flags.no_primary,
                                flags.primary_ot, flags.dcdc_ot,
                                flags.below_bus, flags.sensor_fail,
                                flags.aux_rail_bad,
                                power_delivery_q};
    snap_d.alarm_limits = {flags.power_limit, flags.primary_fault,
                           flags.thermal_trip, flags.ot_warning,
                           flags.in_overcurrent, flags.overvoltage_trip,
                           flags.output_voltage_bad,
                           flags.input_voltage_bad};
    snap_d.volt = data_valid ? volt : rsa_pkg::FILL_WORD;
    snap_d.curr = data_valid ? curr : rsa_pkg::FILL_WORD;
    snap_d.temp = data_valid ? temp_pick : rsa_pkg::FILL_WORD;
  end

  // Frozen at the read address so a reply never mixes two moments.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      snap_q <= '0;
      snap_q.unit_status_high <= rsa_pkg::STATUS_HIGH_RESET;
      snap_q.unit_status_low <= rsa_pkg::STATUS_LOW_RESET;
      snap_q.alarm_hardware <= rsa_pkg::ALARM_RESET;
      snap_q.alarm_thermal_fan <= rsa_pkg::ALARM_RESET;
      snap_q.alarm_limits <= rsa_pkg::ALARM_RESET;
    end else if (snap_take) begin
      snap_q <= snap_d;
    end
  end

  sequence s_byte_hit;
    byte_done && (state_q != rsa_pkg::ST_ADDR || addr_hit);
  endsequence

  sequence s_load(logic [7:0] c, logic [3:0] i);
    load_now && eff_cmd == c && idx_q == i;
  endsequence

  sequence s_benign_fail;
    (host_oring_fail || self_oring_fail) && !oring_destructive &&
    !shutdown_req;
  endsequence

  a_ack_drive: assert property (s_byte_hit |=> sda_oe && !sda_out)
    else $error("received byte was not acknowledged");
  a_block_count: assert property (
    s_load(rsa_pkg::CMD_SUMMARY, 4'h0) |=> byte_q == 8'h0B)
    else $error("summary reply does not open with count 11");
  a_alarm_count: assert property (
    s_load(rsa_pkg::CMD_ALARM, 4'h0) |=> byte_q == 8'h03)
    else $error("alarm block reply does not open with count 3");
  a_summary_head: assert property (
    s_load(rsa_pkg::CMD_SUMMARY, 4'h1) |=> byte_q == snap_q.unit_status_high)
    else $error("summary reply second byte is not status high");
  a_volt_low_first: assert property (
    s_load(rsa_pkg::CMD_SUMMARY, 4'h6) |=> byte_q == snap_q.volt[7:0])
    else $error("voltage high byte sent before low byte");
  a_word_order: assert property (
    s_load(rsa_pkg::CMD_UNIT, 4'h0) |=> byte_q == snap_q.unit_status_high)
    else $error("unit status word does not start with status high");
  a_alarm_order: assert property (
    s_load(rsa_pkg::CMD_ALARM, 4'h1) |=> byte_q == snap_q.alarm_hardware)
    else $error("alarm reply does not start with hardware alarms");
  a_nearest_temp: assert property (snap_take && data_valid |=>
    snap_q.temp == $past(temp_pick))
    else $error("summary temperature is not the nearest to trip");
  a_fill_ones: assert property (snap_take && !data_valid |=>
    snap_q.volt == 16'hFFFF && snap_q.temp == 16'hFFFF &&
    snap_q.curr == 16'hFFFF)
    else $error("stale analog data not replaced by ones");
  a_unused_zero: assert property (snap_take |=>
    snap_q.alarm_hardware[2:1] == 2'b00 &&
    snap_q.unit_status_high[4] == 1'b0)
    else $error("unused status or alarm bit reads one");
  a_remote_level: assert property (snap_take |=>
    snap_q.unit_status_high[0] == $past(rem_s2_q))
    else $error("remote on/off level wrong in status high");
  a_share_alarm: assert property (
    (share_ma > 16'h2710) ##1 snap_take |=> snap_q.alarm_thermal_fan[0])
    else $error("power delivery alarm missing above share limit");
  a_oring_trip: assert property (oring_destructive |=>
    shutdown_req && snap_d.unit_status_low[4])
    else $error("destructive or'ing fault did not shut down");
  a_oring_benign: assert property (s_benign_fail |=>
    !shutdown_req && oring_fault_q)
    else $error("benign or'ing fault was lost or caused shutdown");

endmodule // status_readback
`default_nettype wire

// [bench/smbus_host.sv]
// Host master model for the management bus: start, stop and byte transfer.
// Assumes the bench resolves the open-drain data wire from both parties.
`timescale 1ns/1ns
`default_nettype none
module smbus_host (
  // Clock
  input wire logic mclk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic gap();
    repeat (6) @(posedge mclk);
  endtask
  // Data only changes well inside the clock low phase.
  task automatic bit_io(input logic b, output logic r);
    gap();
    sda_low <= ~b;
    gap();
    scl <= 1'b1;
    gap();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda_low <= 1'b1;
    gap();
    scl <= 1'b0;
  endtask
  task automatic stop();
    gap();
    sda_low <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    sda_low <= 1'b0;
    gap();
  endtask
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ack_in, ack);
  endtask
endmodule // smbus_host
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the status and alarm readback over the bus.
// Assumes the host model drives the bus and the wire is pulled up.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] aw = {rsa_pkg::SLAVE_ADDR, 1'b0};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic remote_pin = 1'b1;
  logic data_valid = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [15:0] volt = 16'h1234;
  logic [15:0] curr = 16'h5678;
  logic [15:0] share_ma = 16'h2711;
  logic [15:0] temp_a = 16'h0032;
  logic [15:0] trip_a = 16'h0064;
  logic [15:0] temp_b = 16'h0050;
  logic [15:0] trip_b = 16'h005A;
  logic scl, sda_low, sda_out, sda_oe, shutdown_req;
  rsa_pkg::unit_flags_t flags;
  wire logic sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
  logic [7:0] exp_q [$];
  int n_fail = 0;
  int compares = 0;
  always #10 mclk = ~mclk;
  smbus_host smbus_host_inst (.mclk, .sda, .scl, .sda_low);
  status_readback status_readback_inst (.mclk, .rst_b, .scl_in(scl),
    .sda_in(sda), .sda_out, .sda_oe, .remote_pin, .flags, .volt, .curr,
    .temp_a, .trip_a, .temp_b, .trip_b, .share_ma, .data_valid,
    .host_oring_fail(ev[0]), .self_oring_fail(ev[1]),
    .oring_destructive(ev[2]), .restart(ev[3]), .shutdown_req);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
    return x;
  endfunction
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask
  // Command write, repeated start, read of exp_q, then the check byte;
  // a write-only call sends a deliberately wrong check byte instead.
  task automatic rd(input logic [7:0] cmd, input logic only_write);
    logic [7:0] b, pec;
    logic a;
    pec = crc8(crc8(crc8(8'h00, aw), cmd), aw | 8'h01);
    smbus_host_inst.start();
    smbus_host_inst.xfer(aw, 1'b1, b, a);
    chk({7'h0, a}, 8'h00);
    smbus_host_inst.xfer(cmd, 1'b1, b, a);
    chk({7'h0, a}, 8'h00);
    if (only_write) begin
      smbus_host_inst.xfer(~crc8(crc8(8'h00, aw), cmd), 1'b1, b, a);
      chk({7'h0, a}, 8'h00);
    end else begin
      smbus_host_inst.start();
      smbus_host_inst.xfer(aw | 8'h01, 1'b1, b, a);
      chk({7'h0, a}, 8'h00);
      foreach (exp_q[i]) begin
        smbus_host_inst.xfer(8'hFF, 1'b0, b, a);
        chk(b, exp_q[i]);
        pec = crc8(pec, exp_q[i]);
      end
      smbus_host_inst.xfer(8'hFF, 1'b1, b, a);
      chk(b, pec);
    end
    smbus_host_inst.stop();
  endtask
  task automatic t_unit();
    exp_q = '{8'h43, 8'h89};
    rd(rsa_pkg::CMD_UNIT, 1'b0);
    $display("unit status test done");
  endtask
  task automatic t_summary();
    exp_q = '{8'h0B, 8'h43, 8'h89, 8'h80, 8'h81, 8'h20,
              8'h34, 8'h12, 8'h78, 8'h56, 8'h50, 8'h00};
    rd(rsa_pkg::CMD_SUMMARY, 1'b0);
    $display("summary test done");
  endtask
  task automatic t_alarm();
    pulse(4'h2);
    chk({7'h0, shutdown_req}, 8'h00);
    exp_q = '{8'h03, 8'h81, 8'h81, 8'h20};
    rd(rsa_pkg::CMD_ALARM, 1'b0);
    // Host test failure together with a destructive fault.
    pulse(4'h5);
    chk({7'h0, shutdown_req}, 8'h01);
    pulse(4'h8);
    chk({7'h0, shutdown_req}, 8'h00);
    $display("alarm test done");
  endtask
  task automatic t_stale();
    data_valid <= 1'b0;
    share_ma <= 16'h2710;
    remote_pin <= 1'b0;
    flags <= ~flags;
    exp_q = '{8'h0B, 8'h08, 8'h76, 8'h79, 8'h7E, 8'hDF,
              8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    rd(rsa_pkg::CMD_SUMMARY, 1'b0);
    flags <= ~flags;
    remote_pin <= 1'b1;
    $display("stale data test done");
  endtask
  task automatic t_invalid();
    rd(8'hD5, 1'b1);
    exp_q = '{8'hE3, 8'h89};
    rd(rsa_pkg::CMD_UNIT, 1'b0);
    $display("invalid command test done");
  endtask
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    flags = '0;
    flags.oc_hiccup = 1'b1;
    flags.value_range_flag = 1'b1;
    flags.ot_hiccup = 1'b1;
    flags.service_led = 1'b1;
    flags.output_on = 1'b1;
    flags.interlock_open = 1'b1;
    flags.fan_fault = 1'b1;
    flags.thermal_trip = 1'b1;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    t_unit();
    t_summary();
    t_alarm();
    t_stale();
    t_invalid();
    conclude();
  end
  // The five tests need about 9300 cycles; allow several times that.
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
